// ### shared/cof_pkg.sv
// Constants for the conversion output framer: register map, field layout,
// reset values, input select codes and frame byte counts.
// Assumes an APB master with 32-bit data and byte addresses on 8 bits.
//
// Notes on behaviour
// - Select 1101 measures supply difference over four on the internal ref.
// - Select 1100 measures external reference over four on internal ref.
// - Any monitor select bypasses the amplifier and forces unity gain.
// - Temperature mode ignores config register 0 and uses internal ref.
// - Temperature result sits in upper 14 bits of the 16-bit word.
// - One step of the temperature result is 0.03125 degrees.
// - Negative temperatures are two's complement across 14 bits.
// - Data go low byte first; high byte is last before any trailer.
// - With counter enabled an 8-bit counter byte precedes result data.
// - Counter starts at 00h, adds one per conversion, wraps after FFh.
// - Counter clears when its enable drops, and on device reset.
// - Integrity covers register readback and results, counter included.
// - Integrity mode 01 sends inverted data copy after the high byte.
// - Integrity mode 10 sends a 16-bit checksum after the high byte.
// - Checksum polynomial x16+x12+x5+1, start FFFFh, over all data bytes.
// - Checksum is remainder of data with sixteen zeros appended.
// - A select code shorts both amplifier inputs to mid-supply.
package cof_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  ADDR_CONFIG  = 8'h00;
  localparam logic [7:0]  ADDR_ROUTE   = 8'h04;
  localparam logic [7:0]  ADDR_RESULT  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
  localparam logic [13:0] CONFIG_RESET = 14'h0000;
  localparam logic [13:0] CONFIG_WMASK = 14'h3FFF;

  // ==========================================================================
  // Configuration field positions
  localparam int SEL_LSB   = 0;
  localparam int GAIN_LSB  = 4;
  localparam int BYP_BIT   = 7;
  localparam int REF_LSB   = 8;
  localparam int TEMP_BIT  = 10;
  localparam int CNT_BIT   = 11;
  localparam int INTEG_LSB = 12;

  // ==========================================================================
  // Codes
  localparam logic [3:0] SEL_SUPPLY_MON = 4'hD;
  localparam logic [3:0] SEL_EXTREF_MON = 4'hC;
  localparam logic [3:0] SEL_MID_SHORT  = 4'hE;
  localparam logic [3:0] SEL_TEMP_PARK  = 4'h0;
  localparam logic [2:0] GAIN_UNITY     = 3'h0;
  localparam logic [1:0] REF_INTERNAL   = 2'h0;
  localparam logic [1:0] INTEG_NONE     = 2'h0;
  localparam logic [1:0] INTEG_INVERT   = 2'h1;
  localparam logic [1:0] INTEG_CRC      = 2'h2;

  // ==========================================================================
  // Checksum and counter
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [7:0]  CNT_RESET = 8'h00;
  localparam logic [1:0]  NBYTE_REG = 2'h1;
  localparam logic [1:0]  NBYTE_RES = 2'h2;
  localparam logic [1:0]  NBYTE_CNT = 2'h3;

  typedef enum logic [1:0] {
    FRM_IDLE,
    FRM_DATA,
    FRM_TRAIL
  } cof_frm_t;

endpackage

// ### logic/cof_crc16.sv
// Byte-wide checksum accumulator for outgoing frame bytes.
// Assumes its user starts each frame with i_init and steps once per byte.
`timescale 1ns/1ps
`default_nettype none
module cof_crc16 (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_init,
  input  wire logic       i_step,
  input  wire logic [7:0] i_byte,
  output logic [15:0]     o_crc,
  output logic [15:0]     o_crc_nxt
);

  // ==========================================================================
  // Next value, MSB first; same as long division with zeros appended
  always_comb begin
    logic [15:0] c;
    c = o_crc;
    for (int k = 7; k >= 0; k--) begin
      if (c[15] ^ i_byte[k]) begin
        c = {c[14:0], 1'b0} ^ cof_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    o_crc_nxt = c;
  end

  // ==========================================================================
  // Accumulator; init wins so a new frame never inherits stale state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crc <= cof_pkg::CRC_INIT;
    end else if (i_init) begin
      o_crc <= cof_pkg::CRC_INIT;
    end else if (i_step) begin
      o_crc <= o_crc_nxt;
    end
  end

endmodule
`default_nettype wire

// ### logic/cof_framer.sv
// Conversion output framer: analog routing overrides, result word format,
// conversion counter and integrity trailer on a byte stream to the UART.
// Assumes all inputs come from logic on i_clk; the UART sender takes a byte
// when o_tx_valid and i_tx_ready are high at a rising edge.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cof_framer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_adc_code,
  input  wire logic [13:0] i_temp_code,
  input  wire logic        i_data_read,
  input  wire logic        i_reg_read,
  input  wire logic [7:0]  i_reg_byte,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_byte,
  input  wire logic        i_tx_ready,
  output logic             o_frame_busy,
  output logic [3:0]       o_mux_sel,
  output logic [2:0]       o_gain,
  output logic             o_pga_bypass,
  output logic [1:0]       o_ref_sel,
  output logic             o_temp_mode
);

  logic [13:0]      cfg_ff;
  logic [7:0]       cnt_ff;
  logic [15:0]      res_word_ff;
  logic [7:0]       res_cnt_ff;
  cof_pkg::cof_frm_t state_ff;
  logic [7:0]       frm_b_ff [0:2];
  logic [1:0]       frm_n_ff, idx_ff, mode_ff;
  logic [15:0]      crc_q, crc_nxt;

  // ==========================================================================
  // Configuration fields
  logic [3:0] cfg_sel;
  logic [2:0] cfg_gain;
  logic [1:0] cfg_ref, cfg_integ;
  logic       cfg_byp, cfg_temp, cfg_cnt, monitor;
  assign cfg_sel   = cfg_ff[cof_pkg::SEL_LSB +: 4];
  assign cfg_gain  = cfg_ff[cof_pkg::GAIN_LSB +: 3];
  assign cfg_byp   = cfg_ff[cof_pkg::BYP_BIT];
  assign cfg_ref   = cfg_ff[cof_pkg::REF_LSB +: 2];
  assign cfg_temp  = cfg_ff[cof_pkg::TEMP_BIT];
  assign cfg_cnt   = cfg_ff[cof_pkg::CNT_BIT];
  assign cfg_integ = cfg_ff[cof_pkg::INTEG_LSB +: 2];
  assign monitor   = (cfg_sel == cof_pkg::SEL_SUPPLY_MON) ||
                     (cfg_sel == cof_pkg::SEL_EXTREF_MON);

  // ==========================================================================
  // APB slave: no wait state; pready and prdata are flops loaded in the setup phase
  logic apb_setup, apb_wr, addr_ok;
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && o_pready && i_pwrite;
  assign addr_ok   = (i_paddr == cof_pkg::ADDR_CONFIG) ||
                     (i_paddr == cof_pkg::ADDR_ROUTE)  ||
                     (i_paddr == cof_pkg::ADDR_RESULT) ||
                     (i_paddr == cof_pkg::ADDR_STATUS);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup && !addr_ok;
      if (apb_setup && !i_pwrite) begin
        case (i_paddr)
          cof_pkg::ADDR_CONFIG: o_prdata <= {18'h00000, cfg_ff};
          cof_pkg::ADDR_ROUTE:  o_prdata <= {21'h000000, o_temp_mode,
                                 o_ref_sel, o_pga_bypass, o_gain, o_mux_sel};
          cof_pkg::ADDR_RESULT: o_prdata <= {8'h00, res_cnt_ff, res_word_ff};
          cof_pkg::ADDR_STATUS: o_prdata <= {24'h000000, cnt_ff};
          default:              o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Config register; unmapped writes are dropped with pslverr
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= cof_pkg::CONFIG_RESET;
    end else if (apb_wr && i_paddr == cof_pkg::ADDR_CONFIG) begin
      cfg_ff <= i_pwdata[13:0] & cof_pkg::CONFIG_WMASK;
    end
  end

  // ==========================================================================
  // Analog routing overrides; temperature mode outranks the monitor codes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mux_sel    <= cof_pkg::SEL_TEMP_PARK;
      o_gain       <= cof_pkg::GAIN_UNITY;
      o_pga_bypass <= 1'b0;
      o_ref_sel    <= cof_pkg::REF_INTERNAL;
      o_temp_mode  <= 1'b0;
    end else if (cfg_temp) begin
      o_mux_sel    <= cof_pkg::SEL_TEMP_PARK;
      o_gain       <= cof_pkg::GAIN_UNITY;
      o_pga_bypass <= 1'b1;
      o_ref_sel    <= cof_pkg::REF_INTERNAL;
      o_temp_mode  <= 1'b1;
    end else if (monitor) begin
      o_mux_sel    <= cfg_sel;
      o_gain       <= cof_pkg::GAIN_UNITY;
      o_pga_bypass <= 1'b1;
      o_ref_sel    <= cof_pkg::REF_INTERNAL;
      o_temp_mode  <= 1'b0;
    end else begin
      // Mid-supply short code passes straight through to the mux
      o_mux_sel    <= cfg_sel;
      o_gain       <= cfg_gain;
      o_pga_bypass <= cfg_byp;
      o_ref_sel    <= cfg_ref;
      o_temp_mode  <= 1'b0;
    end
  end

  // ==========================================================================
  // Conversion counter; held at zero while disabled so re-enable restarts
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= cof_pkg::CNT_RESET;
    end else if (!cfg_cnt) begin
      cnt_ff <= cof_pkg::CNT_RESET;
    end else if (i_conv_done) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Result latch; temperature code left-justified, low bits zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      res_word_ff <= 16'h0000;
      res_cnt_ff  <= cof_pkg::CNT_RESET;
    end else if (i_conv_done) begin
      res_word_ff <= cfg_temp ? {i_temp_code, 2'b00}
                              : i_adc_code;
      res_cnt_ff  <= cfg_cnt ? cnt_ff + 8'h01 : cof_pkg::CNT_RESET;
    end
  end

  // ==========================================================================
  // Frame engine; requests arriving while busy are ignored
  logic       accept, last;
  logic [1:0] idx_nx;
  assign accept = o_tx_valid && i_tx_ready;
  assign last   = (idx_ff == frm_n_ff - 2'h1);
  assign idx_nx = idx_ff + 2'h1;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff    <= cof_pkg::FRM_IDLE;
      o_tx_valid  <= 1'b0;
      o_tx_byte   <= 8'h00;
      frm_b_ff    <= '{default: 8'h00};
      frm_n_ff    <= cof_pkg::NBYTE_REG;
      idx_ff      <= 2'h0;
      mode_ff     <= cof_pkg::INTEG_NONE;
    end else begin
      case (state_ff)
        cof_pkg::FRM_IDLE: begin
          idx_ff  <= 2'h0;
          mode_ff <= cfg_integ;
          if (i_data_read && cfg_cnt) begin
            // Counter byte leads, then low, then high
            frm_b_ff[0] <= res_cnt_ff;
            frm_b_ff[1] <= res_word_ff[7:0];
            frm_b_ff[2] <= res_word_ff[15:8];
            frm_n_ff    <= cof_pkg::NBYTE_CNT;
            o_tx_byte   <= res_cnt_ff;
            o_tx_valid  <= 1'b1;
            state_ff    <= cof_pkg::FRM_DATA;
          end else if (i_data_read) begin
            frm_b_ff[0] <= res_word_ff[7:0];
            frm_b_ff[1] <= res_word_ff[15:8];
            frm_n_ff    <= cof_pkg::NBYTE_RES;
            o_tx_byte   <= res_word_ff[7:0];
            o_tx_valid  <= 1'b1;
            state_ff    <= cof_pkg::FRM_DATA;
          end else if (i_reg_read) begin
            frm_b_ff[0] <= i_reg_byte;
            frm_n_ff    <= cof_pkg::NBYTE_REG;
            o_tx_byte   <= i_reg_byte;
            o_tx_valid  <= 1'b1;
            state_ff    <= cof_pkg::FRM_DATA;
          end
        end
        cof_pkg::FRM_DATA: begin
          if (accept && !last) begin
            idx_ff    <= idx_nx;
            o_tx_byte <= frm_b_ff[idx_nx];
          end else if (accept) begin
            idx_ff <= 2'h0;
            case (mode_ff)
              cof_pkg::INTEG_INVERT: begin
                o_tx_byte <= ~frm_b_ff[0];
                state_ff  <= cof_pkg::FRM_TRAIL;
              end
              cof_pkg::INTEG_CRC: begin
                o_tx_byte <= crc_nxt[15:8];
                state_ff  <= cof_pkg::FRM_TRAIL;
              end
              default: begin
                // Code 11 behaves as no trailer
                o_tx_valid <= 1'b0;
                state_ff   <= cof_pkg::FRM_IDLE;
              end
            endcase
          end
        end
        cof_pkg::FRM_TRAIL: begin
          if (accept && mode_ff == cof_pkg::INTEG_INVERT && !last) begin
            idx_ff    <= idx_nx;
            o_tx_byte <= ~frm_b_ff[idx_nx];
          end else if (accept && mode_ff == cof_pkg::INTEG_CRC &&
                       idx_ff == 2'h0) begin
            idx_ff    <= 2'h1;
            o_tx_byte <= crc_q[7:0];
          end else if (accept) begin
            o_tx_valid <= 1'b0;
            state_ff   <= cof_pkg::FRM_IDLE;
          end
        end
        default: begin
          o_tx_valid <= 1'b0;
          state_ff   <= cof_pkg::FRM_IDLE;
        end
      endcase
    end
  end

  // Busy flag mirrors the engine, registered for a clean output
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_busy <= 1'b0;
    end else begin
      o_frame_busy <= (state_ff != cof_pkg::FRM_IDLE) ||
                      i_data_read || i_reg_read;
    end
  end

  // ==========================================================================
  // Checksum over every data byte as it leaves
  cof_crc16 u_crc (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_init    (state_ff == cof_pkg::FRM_IDLE),
    .i_step    (accept && state_ff == cof_pkg::FRM_DATA),
    .i_byte    (o_tx_byte),
    .o_crc     (crc_q),
    .o_crc_nxt (crc_nxt)
  );

  // ==========================================================================
  // Checks
  property p_supply_ref;
    @(posedge i_clk) disable iff (i_rst)
    (cfg_sel == cof_pkg::SEL_SUPPLY_MON && !cfg_temp) |=>
      (o_ref_sel == cof_pkg::REF_INTERNAL && o_mux_sel == 4'hD);
  endproperty
  a_supply_ref: assert property (p_supply_ref)
    else $error("supply monitor not on internal ref");
  property p_extref_ref;
    @(posedge i_clk) disable iff (i_rst)
    (cfg_sel == cof_pkg::SEL_EXTREF_MON && !cfg_temp) |=>
      (o_ref_sel == cof_pkg::REF_INTERNAL && o_mux_sel == 4'hC);
  endproperty
  a_extref_ref: assert property (p_extref_ref)
    else $error("ext ref monitor not on internal ref");
  property p_monitor_gain;
    @(posedge i_clk) disable iff (i_rst)
    (monitor && !cfg_temp) |=> (o_pga_bypass && o_gain == 3'h0);
  endproperty
  a_monitor_gain: assert property (p_monitor_gain)
    else $error("monitor without unity gain bypass");
  property p_temp_ref;
    @(posedge i_clk) disable iff (i_rst)
    cfg_temp |=> (o_temp_mode && o_ref_sel == cof_pkg::REF_INTERNAL);
  endproperty
  a_temp_ref: assert property (p_temp_ref)
    else $error("temperature mode not on internal ref");
  property p_temp_word;
    @(posedge i_clk) disable iff (i_rst)
    (i_conv_done && cfg_temp) |=>
      (res_word_ff == {$past(i_temp_code), 2'b00});
  endproperty
  a_temp_word: assert property (p_temp_word)
    else $error("temperature word not left-justified");
  property p_cnt_step;
    @(posedge i_clk) disable iff (i_rst)
    (i_conv_done && cfg_cnt) ##1 cfg_cnt |->
      (cnt_ff == $past(cnt_ff) + 8'h01);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter did not step by one");
  property p_cnt_clear;
    @(posedge i_clk) disable iff (i_rst)
    !cfg_cnt |=> (cnt_ff == 8'h00);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("counter not cleared while disabled");
  property p_no_trailer;
    @(posedge i_clk) disable iff (i_rst)
    (state_ff == cof_pkg::FRM_DATA && accept && last &&
     (mode_ff == 2'h0 || mode_ff == 2'h3)) |=> !o_tx_valid;
  endproperty
  a_no_trailer: assert property (p_no_trailer)
    else $error("trailer sent with integrity off");
  property p_inv_copy;
    @(posedge i_clk) disable iff (i_rst)
    (state_ff == cof_pkg::FRM_TRAIL && mode_ff == 2'h1 && o_tx_valid) |->
      (o_tx_byte == ~frm_b_ff[idx_ff]);
  endproperty
  a_inv_copy: assert property (p_inv_copy)
    else $error("inverted copy byte wrong");
  property p_crc_hi;
    @(posedge i_clk) disable iff (i_rst)
    (state_ff == cof_pkg::FRM_DATA && accept && last && mode_ff == 2'h2)
      |=> (o_tx_byte == $past(crc_nxt[15:8]) && o_tx_valid);
  endproperty
  a_crc_hi: assert property (p_crc_hi)
    else $error("checksum high byte wrong");

endmodule
`default_nettype wire

// ### dv/cof_host_model.sv
// Host-side consumer of the framer's byte stream, standing in for the UART.
// Assumes o_ready drives the framer's i_tx_ready on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cof_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_slow,
  output logic            o_ready
);
  // ==========================================================================
  // Receive side
  logic [7:0] rx_q[$];

  // Take a byte on valid and ready; slow mode stalls every other cycle
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ready <= 1'b0;
    end else begin
      if (i_valid && o_ready) begin
        rx_q.push_back(i_byte);  // Bench judges it
      end
      o_ready <= i_slow ? ~o_ready : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### dv/conversion_output_framing_bench.sv
// Self-checking bench for the conversion output framer.
// Assumes the framer answers APB with one access cycle and streams bytes
// to the host model through a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
module conversion_output_framing_bench;
  // ==========================================================================
  // Stimulus and observation
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, conv_done = 1'b0;
  logic [7:0]  paddr = 8'h00, reg_byte = 8'h00, tx_byte;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] adc_code = 16'h0000;
  logic [13:0] temp_code = 14'h0000;
  logic        data_read = 1'b0, reg_read = 1'b0, tx_valid, tx_ready, busy;
  logic [3:0]  mux_sel;
  logic [2:0]  gain;
  logic [1:0]  ref_sel;
  logic        bypass, temp_mode, er, slow = 1'b0;
  int          n_mismatch = 0, n_compared = 0, cycles = 0;

  always #10 clk = ~clk;

  cof_framer dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_conv_done(conv_done), .i_adc_code(adc_code),
    .i_temp_code(temp_code), .i_data_read(data_read), .i_reg_read(reg_read),
    .i_reg_byte(reg_byte), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .i_tx_ready(tx_ready), .o_frame_busy(busy), .o_mux_sel(mux_sel),
    .o_gain(gain), .o_pga_bypass(bypass), .o_ref_sel(ref_sel),
    .o_temp_mode(temp_mode));

  cof_host_model host (.i_clk(clk), .i_rst(rst), .i_valid(tx_valid),
    .i_byte(tx_byte), .i_slow(slow), .o_ready(tx_ready));

  // ==========================================================================
  // Reporting
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Hang guard, well above the roughly 700 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Bus and stream helpers
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cap here: only the bench timeout ends a missing answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conv(input logic [15:0] a, input logic [13:0] t);
    @(posedge clk);
    adc_code <= a;
    temp_code <= t;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask

  // Independent MSB-first checksum, all-ones start, no final inversion
  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (d[i]) begin
      for (int k = 7; k >= 0; k--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][k]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  // One requested frame, compared byte for byte with the expected list
  task automatic frame(input logic rq, input logic [7:0] b, input logic s,
                       input logic [7:0] e[$]);
    int n;
    n = 0;
    host.rx_q.delete();
    @(posedge clk);
    slow <= s;
    reg_byte <= b;
    reg_read <= rq;
    data_read <= ~rq;
    @(posedge clk);
    reg_read <= 1'b0;
    data_read <= 1'b0;
    @(posedge clk);
    chk_byte({7'h00, busy}, 8'h01);
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 100);
    chk_word(32'(host.rx_q.size()), 32'(e.size()));
    foreach (e[i]) begin
      if (i < host.rx_q.size()) begin
        chk_byte(host.rx_q[i], e[i]);
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  // Reset state and an unmapped place
  task automatic t_regs;
    apb(1'b0, cof_pkg::ADDR_CONFIG, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk_word({31'h0, er}, 32'h0000_0001);
  endtask

  // Monitor and temperature overrides on the routing, mid-supply short passing straight through
  task automatic t_route;
    logic [31:0] cfg[4] = '{32'h25D, 32'h25C, 32'h13E, 32'h645};
    logic [31:0] rte[4] = '{32'h08D, 32'h08C, 32'h13E, 32'h480};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cof_pkg::ADDR_CONFIG, cfg[i]);
      apb(1'b0, cof_pkg::ADDR_ROUTE, 32'h0);
      chk_word(rd, rte[i]);
      chk_word({21'h0, temp_mode, ref_sel, bypass, gain, mux_sel},
               rte[i]);
    end
  endtask

  // Temperature word left-justified, low two bits ignored
  task automatic t_temp;
    conv(16'h1234, 14'h3B00);
    apb(1'b0, cof_pkg::ADDR_RESULT, 32'h0);
    chk_word(rd & 32'h00FF_FFFC, 32'h0000_EC00);
    conv(16'h1234, 14'h1000);
    apb(1'b0, cof_pkg::ADDR_RESULT, 32'h0);
    chk_word(rd & 32'h00FF_FFFC, 32'h0000_4000);
  endtask

  // Counter word and every trailer mode, host stalling in odd modes
  task automatic t_count;
    logic [7:0]  d[$];
    logic [7:0]  e[$];
    logic [15:0] c;
    apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h2800);
    repeat (3) conv(16'hA55A, 14'h0000);
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0003);
    apb(1'b0, cof_pkg::ADDR_RESULT, 32'h0);
    chk_word(rd, 32'h0003_A55A);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h800 | (32'(m) << 12));
      d = '{8'h03, 8'h5A, 8'hA5};
      e = d;
      if (m == 1) begin
        foreach (d[i]) e.push_back(~d[i]);
      end
      if (m == 2) begin
        c = crc16(d);
        e.push_back(c[15:8]);
        e.push_back(c[7:0]);
      end
      frame(1'b0, 8'h00, m[0], e);
    end
    apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h1000);
    frame(1'b1, 8'h3C, 1'b1, '{8'h3C, 8'hC3});
  endtask

  // Wrap after FFh, restart on enable toggle and on reset
  task automatic t_wrap;
    // Counter was disabled by the last config write, so it restarts from zero
    apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h800);
    repeat (255) conv(16'h0001, 14'h0000);
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_00FF);
    repeat (2) conv(16'h0001, 14'h0000);
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0001);
    // Toggle from a nonzero count: a missed clear would read 02h
    apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h0);
    apb(1'b1, cof_pkg::ADDR_CONFIG, 32'h800);
    conv(16'h0001, 14'h0000);
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0001);
    conv(16'h0001, 14'h0000);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, cof_pkg::ADDR_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0000);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_temp();
    t_count();
    t_wrap();
    end_of_test();
  end
endmodule
`default_nettype wire
